/* File: serial_sar_adc_interface.sv */
/*
  Control and serial interface of an 8-bit successive-approximation converter
  with one or two analogue inputs. The controller's chip select, serial clock
  and address input are plain inputs synchronous to core_clk; the serial clock
  is edge-detected here. The comparator and resistive ladder sit outside:
  this block drives the trial code and channel selection, and reads back the
  comparator decision.

// How it works
// - Chip select low enables all converter logic.
// - One clock period of settling after selection.
// - Output driven low during settling period.
// - Bits decided by comparing input to trials.
// - Result code is eight bits wide.
// - Each bit sent when decided, MSB first.
// - Conversion ends after eight resolving periods.
// - Chip select high clears and releases output.
// - Address input sampled on rising serial edges.
// - First sampled high is start bit.
// - Dual variant: two assignment bits follow start.
// - Start bit in place selects channel, converts.
// - Assignment picks inputs, mode and positive.
// - Single variant: fixed polarity, no assignment.
// - Dual variant ignores address input while converting.
// - Dual variant resends result LSB first.
// - Input and output may share one wire.
// - Negative differential input gives all zeros.
// - Mode bit high single; polarity high B.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.svh"

module serial_sar_adc_interface #(
  parameter int   RESULT_BITS  = 8,    // Width of the result code
  parameter logic DUAL_CHANNEL = 1'b1  // 1: two inputs with assignment word
) (
  input  wire logic                   core_clk,           // System clock, 125 MHz
  input  wire logic                   rst_n,              // Synchronous reset, active low
  input  wire logic                   cs_n,               // Chip select, active low
  input  wire logic                   serial_clk,         // Controller serial clock
  input  wire logic                   serial_addr_in,     // Start bit and assignment word
  input  wire logic                   comp_greater,       // Comparator: input above trial
  output logic                        data_out,           // Serial result output
  output logic                        data_out_oe,        // Drive enable of the output
  output logic      [RESULT_BITS-1:0] trial_code,         // Trial level to the ladder
  output logic      [RESULT_BITS-1:0] conv_result,        // Code once conversion ends
  output logic                        result_valid,       // Conversion complete
  output logic                        analog_in_a_enable, // Input A switched in
  output logic                        analog_in_b_enable, // Input B switched in
  output logic                        analog_in_b_pos,    // Input B is the positive side
  output logic                        single_diff_select, // 1 single-ended, 0 differential
  output logic                        conv_busy           // Frame past the start bit and any assignment bits
);

  localparam int CNT_W = $clog2(RESULT_BITS);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(RESULT_BITS - 1);
  localparam logic [CNT_W-1:0] PRE_LAST = CNT_W'(RESULT_BITS - 2);
  localparam logic [0:0]       ADDR_LAST = 1'(`ADDR_BITS_DUAL - 1);

  sar_adc_pkg::conv_state_e state;       // Current sequence phase
  sar_adc_pkg::conv_state_e next_state;  // Phase after this cycle
  logic                     sclk_prev;   // Serial clock one cycle ago
  logic [0:0]               addr_cnt;    // Assignment bits received so far
  logic [1:0]               assign_word; // Mode and polarity bits
  logic [CNT_W-1:0]         bit_cnt;     // Position of the output bit within its stream
  logic                     next_data_out;
  logic                     next_oe;
  logic                     sar_busy;    // Approximation still running

  // Edge detection; the controller's clock is sampled as a plain input
  wire sclk_rise = serial_clk & ~sclk_prev;
  wire sclk_fall = ~serial_clk & sclk_prev;

  // Sequence events, all but the msb_last compare gated by an active frame
  wire frame_on     = ~cs_n;
  wire start_seen   = frame_on && (state == sar_adc_pkg::wait_start) && sclk_rise
                      && serial_addr_in;
  wire addr_take    = frame_on && (state == sar_adc_pkg::addr_bits) && sclk_rise;
  wire addr_done    = addr_take && (addr_cnt == ADDR_LAST);
  wire settle_go    = frame_on && (state == sar_adc_pkg::settle_pend) && sclk_fall;
  wire settle_end   = frame_on && (state == sar_adc_pkg::settle) && sclk_fall;
  wire msb_last     = (bit_cnt == LAST_BIT);
  wire msb_fall     = frame_on && (state == sar_adc_pkg::msb_out) && sclk_fall;
  wire lsb_fall     = frame_on && (state == sar_adc_pkg::lsb_out) && sclk_fall;
  wire sar_step     = settle_end || (msb_fall && !msb_last);
  wire eighth_step  = msb_fall && (bit_cnt == PRE_LAST);
  wire select_now   = DUAL_CHANNEL ? addr_done : start_seen;

  // Assignment word as it will stand after the bit now arriving; mode first
  wire [1:0] next_assign = {assign_word[0], serial_addr_in};
  wire       sel_single  = DUAL_CHANNEL ? next_assign[`ASSIGN_SGL_POS] : 1'b0;
  wire       sel_b_pos   = DUAL_CHANNEL ? next_assign[`ASSIGN_POL_POS] : 1'b0;

  // Channel decode: single-ended switches in one input, differential both
  wire       next_a_en   = sel_single ? ~sel_b_pos : 1'b1;
  wire       next_b_en   = sel_single ? sel_b_pos : 1'b1;

  // Bit index for the reversed stream; wraps harmlessly at the last bit
  wire [CNT_W-1:0] lsb_next_idx = bit_cnt + 1'b1;

  // Sequence decisions
  always_comb begin
    next_state = state;
    case (state)
      sar_adc_pkg::wait_start: begin
        // Low samples before the start bit are simply skipped
        if (start_seen) begin
          next_state = DUAL_CHANNEL ? sar_adc_pkg::addr_bits : sar_adc_pkg::settle_pend;
        end
      end
      sar_adc_pkg::addr_bits: begin
        if (addr_done) begin
          next_state = sar_adc_pkg::settle_pend;
        end
      end
      sar_adc_pkg::settle_pend: begin
        if (settle_go) begin
          next_state = sar_adc_pkg::settle;
        end
      end
      sar_adc_pkg::settle: begin
        if (settle_end) begin
          next_state = sar_adc_pkg::msb_out;
        end
      end
      sar_adc_pkg::msb_out: begin
        // Single variant stops after the plain stream
        if (msb_fall && msb_last) begin
          next_state = DUAL_CHANNEL ? sar_adc_pkg::lsb_out : sar_adc_pkg::done;
        end
      end
      sar_adc_pkg::lsb_out: begin
        if (lsb_fall && msb_last) begin
          next_state = sar_adc_pkg::done;
        end
      end
      sar_adc_pkg::done: begin
        next_state = sar_adc_pkg::done;
      end
      default: begin
        next_state = sar_adc_pkg::wait_start;
      end
    endcase
  end

  // Serial output value and drive enable, changing only on falling edges
  always_comb begin
    next_data_out = data_out;
    next_oe       = data_out_oe;
    if (settle_go) begin
      next_data_out = `SETTLE_LEVEL;
      next_oe       = 1'b1;
    end else if (sar_step) begin
      next_data_out = comp_greater;
    end else if (msb_fall && msb_last) begin
      // Dual variant turns round on bit 1; the LSB itself is not repeated
      next_data_out = DUAL_CHANNEL ? conv_result[1] : `DATA_OUT_RST;
      next_oe       = DUAL_CHANNEL;
    end else if (lsb_fall) begin
      next_data_out = msb_last ? `DATA_OUT_RST : conv_result[lsb_next_idx];
      next_oe       = ~msb_last;
    end
  end

  // Edge detector history; not part of the frame, so chip select leaves it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= serial_clk;
    end
  end

  // Sequence state; chip select high clears it like a reset
  always_ff @(posedge core_clk) begin
    if (!rst_n || cs_n) begin
      state <= sar_adc_pkg::wait_start;
    end else begin
      state <= next_state;
    end
  end

  // Address shift register, open only before the conversion begins
  always_ff @(posedge core_clk) begin
    if (!rst_n || cs_n) begin
      assign_word <= `ASSIGN_RST;
      addr_cnt    <= '0;
    end else if (addr_take) begin
      assign_word <= next_assign;
      addr_cnt    <= addr_cnt + 1'b1;
    end
  end

  // Channel selection, applied when the start bit reaches its place
  always_ff @(posedge core_clk) begin
    if (!rst_n || cs_n) begin
      analog_in_a_enable <= `SEL_RST;
      analog_in_b_enable <= `SEL_RST;
      analog_in_b_pos    <= `SEL_RST;
      single_diff_select <= `SEL_RST;
    end else if (select_now) begin
      analog_in_a_enable <= next_a_en;
      analog_in_b_enable <= next_b_en;
      analog_in_b_pos    <= sel_b_pos;
      single_diff_select <= sel_single;
    end
  end

  // Output bit counter: counts bits sent in each stream
  always_ff @(posedge core_clk) begin
    if (!rst_n || cs_n || settle_end) begin
      bit_cnt <= '0;
    end else if (msb_fall && msb_last) begin
      // Reversed stream starts at bit 1, the LSB was just sent
      bit_cnt <= CNT_W'(1);
    end else if (sar_step || lsb_fall) begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // Serial output pin and completion flag
  always_ff @(posedge core_clk) begin
    if (!rst_n || cs_n) begin
      data_out     <= `DATA_OUT_RST;
      data_out_oe  <= `OE_RST;
      result_valid <= 1'b0;
    end else begin
      data_out     <= next_data_out;
      data_out_oe  <= next_oe;
      result_valid <= result_valid | eighth_step;
    end
  end

  // The final trial code is the result; held until chip select rises
  assign conv_result = trial_code;
  assign conv_busy   = (state != sar_adc_pkg::wait_start) && (state != sar_adc_pkg::addr_bits);

  // Approximation register, loaded at the start of settling
  approximation_register #(
    .WIDTH        (RESULT_BITS)
  ) u_approx (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .clear        (cs_n),
    .load         (settle_go),
    .step         (sar_step),
    .comp_greater (comp_greater),
    .trial_code   (trial_code),
    .busy         (sar_busy)
  );

  // Checks on the sequence, sampled on the system clock
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_settle_end;
    (state == sar_adc_pkg::settle) && sclk_fall && !cs_n;
  endsequence

  sequence s_first_bit;
    (state == sar_adc_pkg::msb_out) && data_out_oe && (bit_cnt == '0);
  endsequence

  property p_cs_clears;
    cs_n |=> (state == sar_adc_pkg::wait_start) && !data_out_oe && (trial_code == '0);
  endproperty
  a_cs_clears: assert property (p_cs_clears) else $error("chip select high did not clear");

  property p_addr_hiz;
    (state == sar_adc_pkg::wait_start) || (state == sar_adc_pkg::addr_bits) |-> !data_out_oe;
  endproperty
  a_addr_hiz: assert property (p_addr_hiz) else $error("output driven while addressing");

  property p_low_before_start;
    (state == sar_adc_pkg::wait_start) && sclk_rise && !serial_addr_in && !cs_n
      |=> (state == sar_adc_pkg::wait_start);
  endproperty
  a_low_before_start: assert property (p_low_before_start) else $error("low sample taken as start");

  property p_settle_low;
    (state == sar_adc_pkg::settle) |-> data_out_oe && (data_out == `SETTLE_LEVEL) && sar_busy;
  endproperty
  a_settle_low: assert property (p_settle_low) else $error("settling output not driven low");

  property p_settle_one_period;
    s_settle_end |=> s_first_bit;
  endproperty
  a_settle_one_period: assert property (p_settle_one_period) else $error("settling not one period");

  property p_bit_from_comparator;
    sar_step |=> (data_out == $past(comp_greater)) && data_out_oe;
  endproperty
  a_bit_from_comparator: assert property (p_bit_from_comparator) else $error("sent bit differs");

  property p_change_on_fall;
    $changed(data_out) |-> $past(sclk_fall) || $past(cs_n);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall) else $error("output changed off a falling edge");

  property p_lsb_stream;
    lsb_fall && !msb_last |=> (data_out == conv_result[$past(lsb_next_idx)]);
  endproperty
  a_lsb_stream: assert property (p_lsb_stream) else $error("reversed stream bit wrong");

  property p_di_ignored;
    conv_busy && !cs_n |=> $stable(assign_word);
  endproperty
  a_di_ignored: assert property (p_di_ignored) else $error("address input taken while converting");

  property p_valid_after_eight;
    $rose(result_valid) |-> (state == sar_adc_pkg::msb_out) && (bit_cnt == LAST_BIT) && !sar_busy;
  endproperty
  a_valid_after_eight: assert property (p_valid_after_eight) else $error("completion not after 8 bits");

  property p_done_hiz;
    (state == sar_adc_pkg::done) |-> !data_out_oe;
  endproperty
  a_done_hiz: assert property (p_done_hiz) else $error("output driven after last bit");

  property p_single_one_input;
    (state == sar_adc_pkg::settle) && single_diff_select |-> analog_in_a_enable ^ analog_in_b_enable;
  endproperty
  a_single_one_input: assert property (p_single_one_input) else $error("single-ended enables wrong");

  // Single variant never takes assignment bits, so its selection is fixed
  property p_single_fixed;
    !DUAL_CHANNEL && conv_busy |-> analog_in_a_enable && analog_in_b_enable
      && !analog_in_b_pos && !single_diff_select;
  endproperty
  a_single_fixed: assert property (p_single_fixed) else $error("single variant selection not fixed");

  // Each taken bit enters at the bottom, so the mode bit ends up high
  property p_mode_first;
    addr_take |=> (assign_word == {$past(assign_word[0]), $past(serial_addr_in)});
  endproperty
  a_mode_first: assert property (p_mode_first) else $error("assignment bits out of order");

endmodule : serial_sar_adc_interface

`default_nettype wire

/* File: sar_adc_consts.svh */
/*
  Shared constant macros for the serial successive-approximation converter
  control logic: assignment-word layout, reset values and output levels.
  Assumes it is included by bare name from the design files that use it.
*/
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// Assignment bits that follow the start bit on the dual-channel variant
`define ADDR_BITS_DUAL  2
// Field positions after both bits have been shifted in (first bit lands high)
`define ASSIGN_SGL_POS  1
`define ASSIGN_POL_POS  0
// Reset values of the serial output and the channel selection
`define DATA_OUT_RST    1'b0
`define OE_RST          1'b0
`define SEL_RST         1'b0
`define ASSIGN_RST      2'h0
// Level driven during the multiplexer settling period
`define SETTLE_LEVEL    1'b0

`endif

/* File: sar_adc_pkg.sv */
/*
  Types of the serial converter control logic: the conversion sequence states.
  Assumes nothing of its surroundings; constants live in sar_adc_consts.svh.
*/
`default_nettype none

package sar_adc_pkg;

  // Conversion sequence, one state per phase of a chip-select frame
  typedef enum logic [2:0] {
    wait_start,   // Looking for the first high on the address input
    addr_bits,    // Shifting in the channel assignment word
    settle_pend,  // Channel applied, waiting for the falling edge
    settle,       // Settling period, output driven low
    msb_out,      // Resolving and sending bits, most significant first
    lsb_out,      // Resending the result, least significant first
    done          // Output released until chip select rises
  } conv_state_e;

endpackage : sar_adc_pkg

`default_nettype wire

/* File: approximation_register.sv */
/*
  Successive-approximation register: holds the trial code driven to the
  comparator ladder and decides one bit per step, most significant first.
  Assumes load and step are one-cycle pulses of core_clk and that the
  comparator answer is valid when step is high.
*/
`timescale 1ns/1ps
`default_nettype none

module approximation_register #(
  parameter int WIDTH = 8                 // Result width in bits
) (
  input  wire logic             core_clk,     // System clock
  input  wire logic             rst_n,        // Synchronous reset, active low
  input  wire logic             clear,        // Frame abort, clears everything
  input  wire logic             load,         // Begin a new approximation
  input  wire logic             step,         // Decide the bit under test
  input  wire logic             comp_greater, // Input above the trial level
  output logic      [WIDTH-1:0] trial_code,   // Trial level, final code at end
  output logic                  busy          // A bit is still under test
);

  // Only the top bit set: the first trial is mid-scale
  localparam logic [WIDTH-1:0] MID_SCALE = {1'b1, {(WIDTH-1){1'b0}}};

  logic [WIDTH-1:0] mask;        // Bit currently under test

  // Keep or drop the bit under test, then try the next lower one
  always_ff @(posedge core_clk) begin
    if (!rst_n || clear) begin
      trial_code <= '0;
      mask       <= '0;
    end else if (load) begin
      trial_code <= MID_SCALE;
      mask       <= MID_SCALE;
    end else if (step && (mask != '0)) begin
      // A negative input never beats any trial, so the code ends at zero
      trial_code <= (comp_greater ? trial_code : (trial_code & ~mask)) | (mask >> 1);
      mask       <= mask >> 1;
    end
  end

  assign busy = (mask != '0);

endmodule : approximation_register

`default_nettype wire

/* File: link_ctrl_model.sv */
/*
  Behavioural controlling processor for the serial converter link: drives
  chip select, the serial clock and the address line, and samples the
  serial output just before each rising serial edge after the start and assignment bits.
  Assumes core_clk is the bench clock and the converter changes its output
  within a few core cycles of a serial fall.
*/
`timescale 1ns/1ps
`default_nettype none

module link_ctrl_model (
  input  wire logic       core_clk,       // Bench clock
  input  wire logic       data_out,       // Serial result from the converter
  input  wire logic       data_out_oe,    // Converter drives the output
  output logic            cs_n,           // Chip select, active low
  output logic            serial_clk,     // Serial clock, still between frames
  output logic            serial_addr_in  // Start bit and assignment word
);
  localparam int HALF = 4;  // Core cycles per serial phase, above the 1 needed
  logic [7:0] got_msb;      // Captured first stream
  logic [7:0] got_lsb;      // Captured second stream, bit 0 unused
  logic       got_settle;   // Output driven low before the first bit
  logic       got_oe_end;   // Drive enable after the last bit
  // Released line has no pull, so show the inverse to catch a late drive
  wire logic  line_val = data_out_oe ? data_out : ~data_out;

  // Idle link: deselected, clock parked low
  initial begin
    cs_n           = 1'b1;
    serial_clk     = 1'b0;
    serial_addr_in = 1'b0;
  end

  // Wait n core edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // One frame; stop_at aborts after that rise, 0 runs to the end
  task automatic frame(input logic [1:0] asg, input bit dual, input int lead, input int stop_at);
    int na;
    int r;
    int last;
    na         = dual ? 3 : 1;
    last       = dual ? na + 17 : na + 10;
    got_msb    = 'x;
    got_lsb    = '0;
    got_settle = 1'b0;
    got_oe_end = 1'bx;
    tick(1);
    cs_n = 1'b0;
    for (int k = 1; k <= lead + last; k++) begin
      r = k - lead;
      // Leading lows, start, mode then polarity; afterwards the line toggles
      if (r < 1) serial_addr_in = 1'b0;
      else if (r == 1) serial_addr_in = 1'b1;
      else if (r <= na) serial_addr_in = asg[na - r];
      else serial_addr_in = ~serial_addr_in;
      tick(HALF);
      // Sample where a shift register would, just ahead of the rise
      if (r == na + 1) got_settle = data_out_oe & ~data_out;
      if (r >= na + 2 && r <= na + 9) got_msb[na + 9 - r] = line_val;
      if (dual && r >= na + 10 && r <= na + 16) got_lsb[r - na - 9] = line_val;
      if (r == last) got_oe_end = data_out_oe;
      serial_clk = 1'b1;
      tick(HALF);
      serial_clk = 1'b0;
      // Abort leaves the frame with the clock already parked
      if (k == stop_at) begin
        cs_n = 1'b1;
        return;
      end
    end
    tick(HALF);
    cs_n           = 1'b1;
    serial_addr_in = 1'b0;
    tick(2);
  endtask : frame
endmodule : link_ctrl_model

`default_nettype wire

/* File: test_serial_sar_adc_interface.sv */
/*
  Self-checking bench: a dual-channel and a single-channel converter, each
  driven by its own link model, with a comparator model in the bench.
  Assumes the analogue input sits half a step above its code, so an ideal
  conversion returns exactly the positive-minus-negative code.
*/
`timescale 1ns/1ps
`default_nettype none

module test_serial_sar_adc_interface;
  logic       core_clk;                       // 125 MHz bench clock
  logic       rst_n;                          // Synchronous reset, active low
  logic       cs_n, serial_clk, addr_in;      // Dual link
  logic       cs_n_s, serial_clk_s, addr_in_s;// Single link
  logic       comp_greater, comp_s;           // Comparator answers
  logic       data_out, data_out_oe, result_valid, conv_busy;
  logic       data_out_s, data_out_oe_s, sgl_s, b_pos_s;
  logic       a_en_s, b_en_s, busy_s;         // Single channel selection
  logic       a_en, b_en, b_pos, sgl;         // Dual channel selection
  logic [7:0] trial_code, conv_result, trial_s;
  logic [7:0] va, vb;                         // Analogue levels as codes
  logic [3:0] cap_sel;                        // Selection seen while busy
  logic [3:0] cap_sel_s;                      // Single selection while busy
  logic [7:0] cap_res;                        // Result seen when valid
  logic [7:0] exp;                            // Expected code
  int         failures = 0;
  int         checks   = 0;
  int         cycles   = 0;
  logic [1:0] t_asg [5] = '{2'b10, 2'b11, 2'b00, 2'b01, 2'b10};
  logic [7:0] t_va  [5] = '{8'hA5, 8'h20, 8'hC0, 8'h90, 8'hFF};
  logic [7:0] t_vb  [5] = '{8'h33, 8'h3C, 8'h41, 8'h10, 8'h00};

  // Comparator: positive side minus negative side against the trial level
  function automatic logic cmp(input logic sg, input logic bp, input logic [7:0] a, b, tr);
    int p;
    int n;
    p = bp ? int'(b) : int'(a);
    n = sg ? 0 : (bp ? int'(a) : int'(b));
    return (p - n) >= int'(tr);
  endfunction : cmp

  // Expected code; a negative difference gives zero
  function automatic logic [7:0] code_of(input logic [1:0] asg, input logic [7:0] a, b);
    int p;
    int n;
    p = asg[0] ? int'(b) : int'(a);
    n = asg[1] ? 0 : (asg[0] ? int'(a) : int'(b));
    return (p > n) ? 8'(p - n) : 8'h00;
  endfunction : code_of

  assign comp_greater = cmp(sgl, b_pos, va, vb, trial_code);
  assign comp_s       = cmp(sgl_s, b_pos_s, va, vb, trial_s);

  serial_sar_adc_interface #(.RESULT_BITS(8), .DUAL_CHANNEL(1'b1)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .serial_clk(serial_clk),
    .serial_addr_in(addr_in), .comp_greater(comp_greater), .data_out(data_out),
    .data_out_oe(data_out_oe), .trial_code(trial_code), .conv_result(conv_result),
    .result_valid(result_valid), .analog_in_a_enable(a_en), .analog_in_b_enable(b_en),
    .analog_in_b_pos(b_pos), .single_diff_select(sgl), .conv_busy(conv_busy));
  serial_sar_adc_interface #(.RESULT_BITS(8), .DUAL_CHANNEL(1'b0)) u_dut_single (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n_s), .serial_clk(serial_clk_s),
    .serial_addr_in(addr_in_s), .comp_greater(comp_s), .data_out(data_out_s),
    .data_out_oe(data_out_oe_s), .trial_code(trial_s), .conv_result(), .result_valid(),
    .analog_in_a_enable(a_en_s), .analog_in_b_enable(b_en_s), .analog_in_b_pos(b_pos_s),
    .single_diff_select(sgl_s), .conv_busy(busy_s));
  link_ctrl_model u_link (.core_clk(core_clk), .data_out(data_out), .data_out_oe(data_out_oe),
    .cs_n(cs_n), .serial_clk(serial_clk), .serial_addr_in(addr_in));
  link_ctrl_model u_link_s (.core_clk(core_clk), .data_out(data_out_s), .data_out_oe(data_out_oe_s),
    .cs_n(cs_n_s), .serial_clk(serial_clk_s), .serial_addr_in(addr_in_s));

  // Clock, 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Selection and result vanish at chip-select rise, so catch them here
  always @(posedge core_clk) begin
    if (conv_busy) cap_sel <= {a_en, b_en, b_pos, sgl};
    if (result_valid) cap_res <= conv_result;
    if (busy_s) cap_sel_s <= {a_en_s, b_en_s, b_pos_s, sgl_s};
  end

  // Hang guard, well above the roughly 1240 cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      stop_test();
    end
  end

  // Shared comparison
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  // Counts, verdict and end of run
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  initial begin
    rst_n = 1'b0;
    va    = 8'h00;
    vb    = 8'h00;
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b1;
    check("idle outputs", {4'h0, data_out, data_out_oe, result_valid, conv_busy}, 8'h00);
    check("idle trial", trial_code, 8'h00);
    $display("test reset done");

    // Every assignment code, with growing numbers of leading lows
    for (int i = 0; i < 5; i++) begin
      va      = t_va[i];
      vb      = t_vb[i];
      exp     = code_of(t_asg[i], va, vb);
      cap_sel = 'x;
      cap_res = 'x;
      u_link.frame(t_asg[i], 1'b1, i, 0);
      check("settle low", {7'h00, u_link.got_settle}, 8'h01);
      check("msb stream", u_link.got_msb, exp);
      check("lsb stream", u_link.got_lsb, {exp[7:1], 1'b0});
      check("released", {7'h00, u_link.got_oe_end}, 8'h00);
      check("result", cap_res, exp);
      check("selection", {4'h0, cap_sel},
            {4'h0, ~t_asg[i][1] | ~t_asg[i][0], ~t_asg[i][1] | t_asg[i][0], t_asg[i][0], t_asg[i][1]});
      $display("test assignment %0d done", i);
    end

    // Abort in mid-stream, then a clean frame
    va = 8'h77;
    vb = 8'h00;
    u_link.frame(2'b10, 1'b1, 0, 6);
    u_link.tick(2);
    check("abort outputs", {4'h0, data_out, data_out_oe, result_valid, conv_busy}, 8'h00);
    check("abort trial", trial_code, 8'h00);
    u_link.frame(2'b10, 1'b1, 0, 0);
    check("after abort", u_link.got_msb, 8'h77);
    $display("test abort done");

    // Single variant: fixed differential, no assignment bits, no second stream
    va = 8'h9B;
    vb = 8'h41;
    cap_sel_s = 'x;
    u_link_s.frame(2'b00, 1'b0, 1, 0);
    check("single selection", {4'h0, cap_sel_s}, 8'h0C);
    check("single settle", {7'h00, u_link_s.got_settle}, 8'h01);
    check("single msb", u_link_s.got_msb, 8'h5A);
    check("single release", {7'h00, u_link_s.got_oe_end}, 8'h00);
    $display("test single done");
    stop_test();
  end
endmodule : test_serial_sar_adc_interface

`default_nettype wire
